// >>> src_speed_ref_cond.sv
// Speed reference conditioning: offset utility, filter, ramp, zero clamp.
`timescale 1ns/1ps
`include "src_params.svh"
module src_speed_ref_cond #(
    parameter int MS_CYC = `SRC_MS_CYC,
    parameter int FLASH_CYC = `SRC_FLASH_MS * `SRC_MS_CYC,
    parameter logic [15:0] MAX_SPEED = 16'h1770,
    parameter logic [15:0] POS_GAIN = 16'h0004
)(
    // Clock, reset and clock enable
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CE,
    // Parameter access from the operator panel
    input wire logic PARAM_WE,
    input wire logic [1:0] PARAM_SEL,
    input wire logic [15:0] PARAM_WDATA,
    input wire logic PARAM_INIT,
    output logic [15:0] PARAM_RDATA,
    // Offset utility keys and conditions
    input wire logic KEY_DATA,
    input wire logic KEY_UP,
    input wire logic KEY_DOWN,
    input wire logic KEY_SET,
    input wire logic WRITE_PERMIT,
    input wire logic MAIN_POWER_ON,
    input wire logic SERVO_ON,
    // Offset utility display
    output logic UTIL_ACTIVE,
    output logic DISP_NO_OP,
    output logic DISP_DONE,
    output logic DISP_SERVO_READY,
    output logic signed [15:0] DISP_OFFSET,
    output logic signed [15:0] OFFSET,
    // Speed path
    input wire logic [3:0] CONTROL_METHOD_SELECT,
    input wire logic CLAMP_REQUEST,
    input wire logic signed [15:0] SPEED_REF_IN,
    input wire logic signed [31:0] FEEDBACK_POS,
    output logic signed [15:0] SPEED_CMD,
    output logic CLAMP_ACTIVE
);
    logic [15:0] accel, decel, filt_tc, level;
    logic [15:0] next_accel, next_decel, next_filt_tc, next_level;
    logic [15:0] next_rdata;

    function automatic logic [15:0] clip(input logic [15:0] v);
        return (v > `SRC_SET_MAX) ? `SRC_SET_MAX : v;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [48:0] v);
        if (v > 49'sh0_7FFF)
            return 16'sh7FFF;
        else if (v < -49'sh0_8000)
            return -16'sh8000;
        else
            return v[15:0];
    endfunction

    // Settings take effect on the next cycle; the filter time constant applies from the filter's next sample.
    always_comb
    begin
        next_accel = accel;
        next_decel = decel;
        next_filt_tc = filt_tc;
        next_level = level;
        if (PARAM_INIT)
        begin
            next_accel = `SRC_ACCEL_RST;
            next_decel = `SRC_DECEL_RST;
            next_filt_tc = `SRC_FILT_RST;
            next_level = `SRC_LEVEL_RST;
        end
        else if (PARAM_WE)
        begin
            unique case (PARAM_SEL)
                `SRC_SEL_ACCEL: next_accel = clip(PARAM_WDATA);
                `SRC_SEL_DECEL: next_decel = clip(PARAM_WDATA);
                `SRC_SEL_FILT: next_filt_tc = PARAM_WDATA;
                `SRC_SEL_LEVEL: next_level = clip(PARAM_WDATA);
            endcase
        end
        unique case (PARAM_SEL)
            `SRC_SEL_ACCEL: next_rdata = next_accel;
            `SRC_SEL_DECEL: next_rdata = next_decel;
            `SRC_SEL_FILT: next_rdata = next_filt_tc;
            `SRC_SEL_LEVEL: next_rdata = next_level;
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            accel <= `SRC_ACCEL_RST;
            decel <= `SRC_DECEL_RST;
            filt_tc <= `SRC_FILT_RST;
            level <= `SRC_LEVEL_RST;
            PARAM_RDATA <= `SRC_ACCEL_RST;
        end
        else if (CE)
        begin
            accel <= next_accel;
            decel <= next_decel;
            filt_tc <= next_filt_tc;
            level <= next_level;
            PARAM_RDATA <= next_rdata;
        end
    end

    // Offset utility. The offset register sits outside the parameter
    // set, which is why initialization never reaches it.
    src_pkg::src_util_state_type state, next_state;
    logic signed [15:0] edit, next_edit, next_offset;
    logic [26:0] flash, next_flash;
    logic flash_end;

    assign flash_end = (flash == 27'(FLASH_CYC - 1));

    always_comb
    begin
        next_state = state;
        next_edit = edit;
        next_offset = OFFSET;
        next_flash = flash;
        unique case (state)
            src_pkg::UT_IDLE:
                if (KEY_DATA)
                begin
                    next_flash = '0;
                    if (WRITE_PERMIT && MAIN_POWER_ON)
                        next_state = src_pkg::UT_ARMED;
                    else
                        next_state = src_pkg::UT_NOOP;
                end
            src_pkg::UT_NOOP, src_pkg::UT_DONE:
                if (flash_end)
                    next_state = (state == src_pkg::UT_NOOP) ?
                        src_pkg::UT_IDLE : src_pkg::UT_FINISH;
                else
                    next_flash = flash + 27'h000_0001;
            src_pkg::UT_ARMED:
                if (KEY_DATA)
                begin
                    if (SERVO_ON)
                    begin
                        next_state = src_pkg::UT_ADJUST;
                        next_edit = OFFSET;
                    end
                    else
                        next_state = src_pkg::UT_IDLE;
                end
            src_pkg::UT_ADJUST:
                if (!SERVO_ON)
                    next_state = src_pkg::UT_ARMED;
                else if (KEY_SET)
                begin
                    next_offset = edit;
                    next_flash = '0;
                    next_state = src_pkg::UT_DONE;
                end
                else if (KEY_UP && edit != 16'sh7FFF)
                    next_edit = edit + 16'sh0001;
                else if (KEY_DOWN && edit != -16'sh8000)
                    next_edit = edit - 16'sh0001;
            src_pkg::UT_FINISH:
                if (KEY_DATA)
                    next_state = src_pkg::UT_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state <= src_pkg::UT_IDLE;
            edit <= '0;
            OFFSET <= '0;
            flash <= '0;
            UTIL_ACTIVE <= 1'b0;
            DISP_NO_OP <= 1'b0;
            DISP_DONE <= 1'b0;
            DISP_SERVO_READY <= 1'b0;
            DISP_OFFSET <= '0;
        end
        else if (CE)
        begin
            state <= next_state;
            edit <= next_edit;
            OFFSET <= next_offset;
            flash <= next_flash;
            UTIL_ACTIVE <= (next_state != src_pkg::UT_IDLE);
            DISP_NO_OP <= (next_state == src_pkg::UT_NOOP);
            DISP_DONE <= (next_state == src_pkg::UT_DONE);
            DISP_SERVO_READY <= (next_state == src_pkg::UT_ARMED) && SERVO_ON;
            DISP_OFFSET <= (next_state == src_pkg::UT_ADJUST) ?
                next_edit : next_offset;
        end
    end

    // Speed path: offset, sample strobe, lag filter, ramp and clamp.
    logic signed [15:0] ref_in, filt, ramp, next_ref_in, next_ramp, next_cmd;
    logic [10:0] smp, next_smp;
    logic [31:0] racc, next_racc, den;
    logic accel_dir, method_a, next_method_a, strap, next_strap;
    logic clamp_cond, next_clamp;
    logic [15:0] tsel;
    logic [16:0] filt_mag;
    logic signed [31:0] hold, next_hold, err;
    logic signed [48:0] prod;
    logic err_small;

    src_lag_filter #(
        .W(16),
        .FRAC(`SRC_FRAC)
    ) u_filter (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CE),
        .sample(smp == 11'(`SRC_SAMPLE_CYC - 1)),
        .tau(filt_tc),
        .x(ref_in),
        .y(filt)
    );

    assign accel_dir = (filt > ramp && ramp >= 0) || (filt < ramp && ramp <= 0);
    assign tsel = accel_dir ? accel : decel;
    assign den = 32'(tsel) * 32'(MS_CYC);
    assign filt_mag = filt[15] ? 17'(-{filt[15], filt}) : {1'b0, filt};
    assign clamp_cond = method_a && CLAMP_REQUEST && (filt_mag < {1'b0, level});
    assign err = hold - FEEDBACK_POS;
    assign err_small = (err >= -32'sd1) && (err <= 32'sd1);
    assign prod = err * $signed({1'b0, POS_GAIN});

    always_comb
    begin
        next_ref_in = sat16(49'(SPEED_REF_IN) + 49'(OFFSET));
        next_smp = (smp == 11'(`SRC_SAMPLE_CYC - 1)) ? '0 : smp + 11'h001;
        next_strap = 1'b1;
        next_method_a = strap ? method_a :
            (CONTROL_METHOD_SELECT == `SRC_METHOD_CLAMP);
        next_ramp = ramp;
        next_racc = racc;
        if (ramp == filt)
            next_racc = '0;
        else if (tsel == 16'h0000)
        begin
            next_ramp = filt;
            next_racc = '0;
        end
        else if (racc + 32'(MAX_SPEED) >= den)
        begin
            // One unit per crossing gives MAX_SPEED units per set time.
            next_racc = racc + 32'(MAX_SPEED) - den;
            next_ramp = (filt > ramp) ? ramp + 16'sh0001
                                      : ramp - 16'sh0001;
        end
        else
            next_racc = racc + 32'(MAX_SPEED);
        next_clamp = clamp_cond;
        next_hold = (clamp_cond && !CLAMP_ACTIVE) ? FEEDBACK_POS : hold;
        if (CLAMP_ACTIVE)
            next_cmd = err_small ? 16'sh0000 : sat16(prod);
        else
            next_cmd = ramp;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ref_in <= '0;
            smp <= '0;
            strap <= 1'b0;
            method_a <= 1'b0;
            ramp <= '0;
            racc <= '0;
            CLAMP_ACTIVE <= 1'b0;
            hold <= '0;
            SPEED_CMD <= '0;
        end
        else if (CE)
        begin
            ref_in <= next_ref_in;
            smp <= next_smp;
            strap <= next_strap;
            method_a <= next_method_a;
            ramp <= next_ramp;
            racc <= next_racc;
            CLAMP_ACTIVE <= next_clamp;
            hold <= next_hold;
            SPEED_CMD <= next_cmd;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    a_refuse_entry: assert property (CE && state == src_pkg::UT_IDLE && KEY_DATA && !WRITE_PERMIT |=> state == src_pkg::UT_NOOP && DISP_NO_OP)
        else $error("Prohibited entry did not flash no-op.");
    a_entry_gate: assert property (CE && state == src_pkg::UT_IDLE && KEY_DATA |=> (state == src_pkg::UT_ARMED) == $past(WRITE_PERMIT && MAIN_POWER_ON))
        else $error("Offset utility entry ignored its preconditions.");
    a_offset_store: assert property (CE && state == src_pkg::UT_ADJUST && SERVO_ON && KEY_SET |=> OFFSET == $past(edit) && DISP_DONE)
        else $error("Confirmed offset was not stored.");
    a_init_keeps: assert property (CE && PARAM_INIT && state != src_pkg::UT_ADJUST |=> $stable(OFFSET) && filt_tc == `SRC_FILT_RST)
        else $error("Initialization disturbed the offset.");
    a_ramp_rate: assert property (CE && accel != 0 && decel != 0 |=> ramp == $past(ramp) || ramp == $past(ramp) + 16'sh0001 || ramp == $past(ramp) - 16'sh0001)
        else $error("Ramp moved more than one unit.");
    a_ramp_pass: assert property (CE && accel == 0 && decel == 0 |=> ramp == $past(filt))
        else $error("Zero ramp time did not pass the step.");
    a_accel_clip: assert property (CE && PARAM_WE && !PARAM_INIT && PARAM_SEL == `SRC_SEL_ACCEL |=> accel == clip($past(PARAM_WDATA)))
        else $error("Acceleration time not written or clipped.");
    a_clamp_on: assert property (CE && clamp_cond |=> CLAMP_ACTIVE &&
        hold == ($past(CLAMP_ACTIVE) ? $past(hold) : $past(FEEDBACK_POS)))
        else $error("Clamp did not engage.");
    a_clamp_off: assert property (CE && !CLAMP_REQUEST |=> !CLAMP_ACTIVE)
        else $error("Clamp stayed on with input open.");
    a_clamp_hold: assert property (CE && CLAMP_ACTIVE && err_small |=> SPEED_CMD == 16'sh0000)
        else $error("Clamp drove motor inside one pulse.");
    a_method_fixed: assert property (strap |=> $stable(method_a))
        else $error("Control method changed without restart.");

    c_noop: cover property (DISP_NO_OP ##1 !DISP_NO_OP);
    c_store: cover property (state == src_pkg::UT_ADJUST ##1 DISP_DONE);
    c_clamp: cover property (CLAMP_ACTIVE && !err_small ##1 CLAMP_ACTIVE);
    c_ramp: cover property (accel != 0 && ramp != filt ##1 ramp != $past(ramp));
endmodule

// >>> src_params.svh
// Constants for the speed reference conditioning block.
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH
`define SRC_CLK_MHZ 125
`define SRC_MS_CYC (`SRC_CLK_MHZ * 1000)
`define SRC_FLASH_MS 1000
`define SRC_SAMPLE_NS 10000
`define SRC_SAMPLE_CYC (`SRC_SAMPLE_NS * `SRC_CLK_MHZ / 1000)
`define SRC_FRAC 16
`define SRC_ACCEL_RST 16'h0000
`define SRC_DECEL_RST 16'h0000
`define SRC_FILT_RST 16'h0028
`define SRC_LEVEL_RST 16'h000A
`define SRC_SET_MAX 16'h2710
`define SRC_METHOD_CLAMP 4'hA
`define SRC_SEL_ACCEL 2'h0
`define SRC_SEL_DECEL 2'h1
`define SRC_SEL_FILT 2'h2
`define SRC_SEL_LEVEL 2'h3
`endif

// >>> src_pkg.sv
// Types for the speed reference conditioning block.
package src_pkg;
    typedef enum logic [2:0] {
        UT_IDLE,
        UT_NOOP,
        UT_ARMED,
        UT_ADJUST,
        UT_DONE,
        UT_FINISH
    } src_util_state_type;
endpackage

// >>> src_lag_filter.sv
// First order lag filter with a serial divider, one update per sample.
`timescale 1ns/1ps
module src_lag_filter #(
    parameter int W = 16,
    parameter int FRAC = 16
)(
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Sample strobe and time constant in samples
    input wire logic sample,
    input wire logic [15:0] tau,
    // Data
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    localparam int AW = W + FRAC;

    logic signed [AW-1:0] acc, next_acc;
    logic signed [W-1:0] next_y;
    logic busy, next_busy, neg, next_neg;
    logic [5:0] cnt, next_cnt;
    logic [16:0] rem, next_rem;
    logic [AW:0] quo, next_quo;
    logic signed [AW:0] diff;
    logic [16:0] den;
    logic [16:0] dv, next_dv;
    logic [17:0] t;
    logic qbit;
    logic [AW:0] q;

    assign diff = $signed({x[W-1], x, {FRAC{1'b0}}}) - $signed({acc[AW-1], acc});
    assign den = {1'b0, tau} + 17'h0_001;
    assign t = {rem, quo[AW]};

    // Each sample moves the output by (x - y) / (tau + 1), so the time
    // constant is tau samples of 0.01 ms; tau of zero passes x straight.
    always_comb
    begin
        next_acc = acc;
        next_busy = busy;
        next_neg = neg;
        next_cnt = cnt;
        next_rem = rem;
        next_quo = quo;
        next_dv = dv;
        qbit = 1'b0;
        q = '0;
        if (!busy)
        begin
            if (sample)
            begin
                if (tau == 16'h0000)
                begin
                    next_acc = {x, {FRAC{1'b0}}};
                end
                else
                begin
                    next_busy = 1'b1;
                    next_cnt = '0;
                    next_rem = '0;
                    next_neg = diff[AW];
                    next_quo = diff[AW] ? -diff : diff;
                    // The divisor is latched here so that a time constant
                    // written mid-division cannot corrupt the result.
                    next_dv = den;
                end
            end
        end
        else
        begin
            qbit = (t >= {1'b0, dv});
            next_rem = qbit ? 17'(t - {1'b0, dv}) : t[16:0];
            q = {quo[AW-1:0], qbit};
            next_quo = q;
            next_cnt = cnt + 6'h01;
            if (cnt == 6'(AW))
            begin
                next_busy = 1'b0;
                next_acc = neg ? acc - $signed(q[AW-1:0])
                               : acc + $signed(q[AW-1:0]);
            end
        end
        next_y = next_acc[AW-1:FRAC];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc <= '0;
            busy <= 1'b0;
            neg <= 1'b0;
            cnt <= '0;
            rem <= '0;
            quo <= '0;
            dv <= '0;
            y <= '0;
        end
        else if (ce)
        begin
            acc <= next_acc;
            busy <= next_busy;
            neg <= next_neg;
            cnt <= next_cnt;
            rem <= next_rem;
            quo <= next_quo;
            dv <= next_dv;
            y <= next_y;
        end
    end
endmodule

// >>> src_host_model.sv
// Host controller model that drives the speed reference and clamp input.
`timescale 1ns/1ps
module src_host_model (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic slow,
    input wire logic signed [15:0] target,
    input wire logic clamp_on,
    input wire logic signed [31:0] displace,
    // Lines into the drive
    output logic signed [15:0] speed_ref,
    output logic clamp_req,
    output logic signed [31:0] feedback_pos
);
    // A slow host slews its analog output upward instead of stepping it; downward moves still step.
    always @(negedge clk)
    begin
        if (slow && target > speed_ref + 16'sh0064)
            speed_ref <= speed_ref + 16'sh0064;
        else
            speed_ref <= target;
        clamp_req <= clamp_on;
        // The machine sits still unless the bench pushes it off position.
        feedback_pos <= 32'sh0001_0000 + displace;
    end
endmodule

// >>> testbench.sv
// Self-checking bench for the speed reference conditioning block.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    localparam int FL = 16;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic init = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [3:0] keys = 4'h0;
    logic permit = 1'b0;
    logic power = 1'b0;
    logic servo = 1'b0;
    logic [3:0] method = 4'hA;
    logic ua, dno, ddone, dsr, ca;
    logic signed [15:0] doff, off, spd, sref;
    logic slow = 1'b0;
    logic clamp_on = 1'b0;
    logic clamp_req;
    logic signed [15:0] tgt = 16'sh0000;
    logic signed [31:0] disp = 32'sh0000_0000;
    logic signed [31:0] fb;
    int bad_count = 0;
    int compares = 0;
    int n, mx, d, w, prev;
    logic [16:0] rows [9] = '{
        {1'b0, 16'h0000}, {1'b0, 16'h0000}, {1'b0, 16'h0028},
        {1'b0, 16'h000A}, {1'b1, 16'h01F4}, {1'b1, 16'h2711},
        {1'b1, 16'h2710}, {1'b1, 16'hFFFF}, {1'b1, 16'h2EE0}};
    logic [15:0] expv [9] = '{16'h0000, 16'h0000, 16'h0028, 16'h000A,
        16'h01F4, 16'h2710, 16'h2710, 16'hFFFF, 16'h2710};
    logic [1:0] sels [9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1,
        2'h2, 2'h3};

    // Maximum speed is cut so that no ramp needs more than one unit a cycle
    // at the shortened millisecond.
    src_speed_ref_cond #(.MS_CYC(20), .FLASH_CYC(FL),
        .MAX_SPEED(16'h0064)) i_dut (
        .CLOCK(clock), .SYS_RST(rst), .CE(1'b1),
        .PARAM_WE(we), .PARAM_SEL(sel), .PARAM_WDATA(wdata),
        .PARAM_INIT(init), .PARAM_RDATA(rdata),
        .KEY_DATA(keys[0]), .KEY_UP(keys[1]), .KEY_DOWN(keys[2]),
        .KEY_SET(keys[3]), .WRITE_PERMIT(permit), .MAIN_POWER_ON(power),
        .SERVO_ON(servo), .UTIL_ACTIVE(ua), .DISP_NO_OP(dno),
        .DISP_DONE(ddone), .DISP_SERVO_READY(dsr), .DISP_OFFSET(doff),
        .OFFSET(off), .CONTROL_METHOD_SELECT(method),
        .CLAMP_REQUEST(clamp_req), .SPEED_REF_IN(sref),
        .FEEDBACK_POS(fb), .SPEED_CMD(spd), .CLAMP_ACTIVE(ca));

    src_host_model i_host (
        .clk(clock), .slow(slow), .target(tgt), .clamp_on(clamp_on),
        .displace(disp), .speed_ref(sref), .clamp_req(clamp_req),
        .feedback_pos(fb));

    initial
    begin
        forever #4 clock = ~clock;
    end

    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic setp(input logic [1:0] s, input logic [15:0] v);
        we = 1'b1;
        sel = s;
        wdata = v;
        cyc(1);
        we = 1'b0;
        cyc(1);
    endtask

    task automatic key(input int k);
        keys[k] = 1'b1;
        cyc(1);
        keys = 4'h0;
        cyc(1);
    endtask

    task automatic do_reset(input logic [3:0] m);
        method = m;
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        cyc(2);
    endtask

    // Waits for the command to move, then times the ramp to its end value.
    task automatic measure(input logic signed [15:0] fin);
        prev = spd;
        for (w = 0; w < 1400 && spd === prev[15:0]; w++)
            cyc(1);
        mx = 0;
        for (n = 0; n < 400; n++)
        begin
            d = spd - prev;
            d = d < 0 ? -d : d;
            mx = d > mx ? d : mx;
            prev = spd;
            if (spd === fin)
                break;
            cyc(1);
        end
    endtask

    task automatic report_and_stop;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(8 * 60000);
        bad_count++;
        report_and_stop;
    end

    initial
    begin
        do_reset(4'hA);
        `CHK({ua, dno, ddone, ca, off, spd}, 36'h0)
        for (int i = 0; i < 9; i++)
        begin
            we = rows[i][16];
            sel = sels[i];
            wdata = rows[i][15:0];
            cyc(1);
            we = 1'b0;
            cyc(1);
            `CHK(rdata, expv[i])
        end
        $display("test settings done");
        key(0);
        `CHK(dno, 1'b1)
        cyc(FL - 2);
        `CHK(dno, 1'b1)
        cyc(5);
        `CHK({dno, ua}, 2'b00)
        permit = 1'b1;
        key(0);
        `CHK(dno, 1'b1)
        cyc(FL + 3);
        power = 1'b1;
        key(0);
        `CHK({ua, dno, dsr}, 3'b100)
        servo = 1'b1;
        cyc(2);
        `CHK(dsr, 1'b1)
        key(0);
        `CHK(doff, 16'sh0000)
        repeat (4) key(1);
        key(2);
        `CHK({doff, off}, {16'sh0003, 16'sh0000})
        key(3);
        `CHK({off, ddone}, {16'sh0003, 1'b1})
        cyc(FL + 3);
        `CHK(ddone, 1'b0)
        key(0);
        `CHK(ua, 1'b0)
        $display("test offset utility done");
        // Zero ramp times, as plain speed control needs.
        // The long filter holds the target back until its constant is zero.
        tgt = 16'sd1000;
        setp(2'h0, 16'h0000);
        setp(2'h1, 16'h0000);
        setp(2'h2, 16'h0000);
        measure(16'sd1003);
        `CHK({n[15:0], mx[15:0]}, {16'h0000, 16'sd1003})
        tgt = -16'sd3;
        measure(16'sh0000);
        $display("test step passthrough done");
        init = 1'b1;
        cyc(1);
        init = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            sel = sels[i];
            cyc(2);
            `CHK(rdata, expv[i])
        end
        `CHK(off, 16'sh0003)
        $display("test init done");
        setp(2'h2, 16'h0000);
        setp(2'h0, 16'h000A);
        setp(2'h1, 16'h0005);
        // Accel: 100 units per 200 cycles; decel: 100 units per 100 cycles.
        tgt = 16'sd47;
        measure(16'sd50);
        `CHK(n >= 96 && n <= 103 && mx <= 1, 1'b1)
        tgt = -16'sd3;
        measure(16'sh0000);
        `CHK(n >= 46 && n <= 53 && mx <= 1, 1'b1)
        $display("test soft start done");
        setp(2'h0, 16'h0000);
        setp(2'h1, 16'h0000);
        setp(2'h2, 16'h0028);
        slow = 1'b1;
        tgt = 16'sd4097;
        prev = spd;
        for (w = 0; w < 1400 && spd === 16'sh0000; w++)
            cyc(1);
        cyc(40);
        `CHK(spd > 16'sh0000 && spd < 16'sd205, 1'b1)
        slow = 1'b0;
        $display("test filter done");
        setp(2'h2, 16'h0000);
        tgt = 16'sd2;
        cyc(1300);
        clamp_on = 1'b1;
        for (w = 0; w < 1400 && ca !== 1'b1; w++)
            cyc(1);
        cyc(3);
        `CHK({ca, spd}, {1'b1, 16'sh0000})
        disp = 32'sd10;
        cyc(4);
        `CHK(spd, -16'sd40)
        disp = -32'sd1;
        cyc(4);
        `CHK(spd, 16'sh0000)
        disp = 32'sh0000_0000;
        tgt = 16'sd50;
        for (w = 0; w < 1400 && ca !== 1'b0; w++)
            cyc(1);
        `CHK(ca, 1'b0)
        tgt = 16'sd2;
        cyc(1300);
        clamp_on = 1'b0;
        cyc(3);
        `CHK(ca, 1'b0)
        $display("test zero clamp done");
        do_reset(4'h0);
        `CHK(off, 16'sh0000)
        method = 4'hA;
        clamp_on = 1'b1;
        cyc(1500);
        `CHK(ca, 1'b0)
        $display("test method select done");
        report_and_stop;
    end
endmodule
